// ### rtl/shm_monitor.sv
// Chosen here: the register offsets and the Avalon-MM slave port.
module shm_monitor #(
	parameter int unsigned MISMATCH_CYCLES = shm_pkg::MISMATCH_CYCLES,
	parameter int unsigned CNT_W = shm_pkg::MISMATCH_CNT_W,
	parameter int unsigned N_OUT = shm_pkg::N_OUT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Safe-halt comparators, channel a and b
	input wire logic safe_halt_in_a_hi_i,
	input wire logic safe_halt_in_a_lo_i,
	input wire logic safe_halt_in_b_hi_i,
	input wire logic safe_halt_in_b_lo_i,
	// Command pins
	input wire logic start_cmd_input_i,
	input wire logic halt_cmd_input_i,
	// Drive conditions, same clock
	input wire logic ext_fault_i,
	input wire logic undervoltage_i,
	input wire logic self_tuning_i,
	input wire logic configuration_i,
	input wire logic dc_braking_i,
	// Avalon-MM slave
	input wire logic [shm_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [shm_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [shm_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Status and outputs
	output logic [2:0] drive_state_param_o,
	output logic torque_off_state_o,
	output logic channel_mismatch_fault_o,
	output logic run_o,
	output logic [N_OUT-1:0] digital_out_o,
	output logic irq_o
);
	localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(MISMATCH_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	shm_pin_if #(.N(shm_pkg::N_PIN)) pins ();

	assign pins.raw[shm_pkg::PIN_A_HI] = safe_halt_in_a_hi_i;
	assign pins.raw[shm_pkg::PIN_A_LO] = safe_halt_in_a_lo_i;
	assign pins.raw[shm_pkg::PIN_B_HI] = safe_halt_in_b_hi_i;
	assign pins.raw[shm_pkg::PIN_B_LO] = safe_halt_in_b_lo_i;
	assign pins.raw[shm_pkg::PIN_START] = start_cmd_input_i;
	assign pins.raw[shm_pkg::PIN_HALT] = halt_cmd_input_i;

	shm_sync #(.N(shm_pkg::N_PIN)) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pins(pins.sync)
	);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic wait_r, wait_nxt;
	logic [shm_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic enable_r, enable_nxt;
	logic fault_rst_r, fault_rst_nxt;
	logic [shm_pkg::IRQ_W-1:0] irq_st_r, irq_st_nxt;
	logic [shm_pkg::IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
	logic [shm_pkg::FSEL_W-1:0] fsel_r [N_OUT];
	logic [shm_pkg::FSEL_W-1:0] fsel_nxt [N_OUT];
	logic irq_r, irq_nxt;

	// Monitor state, declared here for the bus read path
	logic level_a_r, level_a_nxt;
	logic level_b_r, level_b_nxt;
	logic sto_r, sto_nxt;
	logic mismatch_r, mismatch_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic run_r, run_nxt;
	logic start_d_r, start_d_nxt;
	logic ext_d_r, ext_d_nxt;
	shm_pkg::shm_state_t state_r, state_nxt;
	logic [N_OUT-1:0] dout_r, dout_nxt;
	logic any_fault;
	logic [shm_pkg::IRQ_W-1:0] irq_evt;

	logic [shm_pkg::DATA_W-1:0] status_word;
	logic wr_go, rd_go;

	always_comb begin
		status_word = '0;
		status_word[shm_pkg::ST_STATE_LSB +: 3] = state_r;
		status_word[shm_pkg::ST_LEVEL_A] = level_a_r;
		status_word[shm_pkg::ST_LEVEL_B] = level_b_r;
		status_word[shm_pkg::ST_TORQUE_OFF] = sto_r;
		status_word[shm_pkg::ST_MISMATCH] = mismatch_r;
		status_word[shm_pkg::ST_ANY_FAULT] = any_fault;
		status_word[shm_pkg::ST_RUN] = run_r;
	end

	always_comb begin
		// One wait state: request seen, answered the next cycle
		rd_go = avs_read_i & ~wait_r;
		wr_go = avs_write_i & ~wait_r & avs_byteenable_i[0];
		wait_nxt = 1'b1;
		if ((avs_read_i | avs_write_i) & wait_r) begin
			wait_nxt = 1'b0;
		end
		rdata_nxt = rdata_r;
		if (avs_read_i & wait_r) begin
			rdata_nxt = '0;
			unique case (avs_address_i)
				shm_pkg::OFF_CTRL: begin
					rdata_nxt[shm_pkg::CTRL_ENABLE] = enable_r;
				end
				shm_pkg::OFF_STATUS: begin
					rdata_nxt = status_word;
				end
				shm_pkg::OFF_IRQ_ST: begin
					rdata_nxt[shm_pkg::IRQ_W-1:0] = irq_st_r;
				end
				shm_pkg::OFF_IRQ_MASK: begin
					rdata_nxt[shm_pkg::IRQ_W-1:0] = irq_mask_r;
				end
				default: begin
					for (int i = 0; i < N_OUT; i++) begin
						if (avs_address_i == shm_pkg::OFF_FSEL0
							+ shm_pkg::ADDR_W'(i) * shm_pkg::FSEL_STRIDE) begin
							rdata_nxt[shm_pkg::FSEL_W-1:0] = fsel_r[i];
						end
					end
				end
			endcase
		end

		enable_nxt = enable_r;
		fault_rst_nxt = 1'b0;
		irq_mask_nxt = irq_mask_r;
		// Hardware set wins over a write-one clear in the same cycle
		irq_st_nxt = irq_st_r;
		if (wr_go && avs_address_i == shm_pkg::OFF_IRQ_ST) begin
			irq_st_nxt = irq_st_r & ~avs_writedata_i[shm_pkg::IRQ_W-1:0];
		end
		irq_st_nxt = irq_st_nxt | irq_evt;
		for (int i = 0; i < N_OUT; i++) begin
			fsel_nxt[i] = fsel_r[i];
		end
		if (wr_go) begin
			if (avs_address_i == shm_pkg::OFF_CTRL) begin
				enable_nxt = avs_writedata_i[shm_pkg::CTRL_ENABLE];
				fault_rst_nxt = avs_writedata_i[shm_pkg::CTRL_FAULT_RST];
			end
			if (avs_address_i == shm_pkg::OFF_IRQ_MASK) begin
				irq_mask_nxt = avs_writedata_i[shm_pkg::IRQ_W-1:0];
			end
			for (int i = 0; i < N_OUT; i++) begin
				if (avs_address_i == shm_pkg::OFF_FSEL0
					+ shm_pkg::ADDR_W'(i) * shm_pkg::FSEL_STRIDE) begin
					fsel_nxt[i] = avs_writedata_i[shm_pkg::FSEL_W-1:0];
				end
			end
		end
		irq_nxt = |(irq_st_nxt & irq_mask_nxt);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_r <= 1'b1;
			rdata_r <= '0;
			enable_r <= shm_pkg::CTRL_ENABLE_RST;
			fault_rst_r <= 1'b0;
			irq_st_r <= '0;
			irq_mask_r <= '0;
			irq_r <= 1'b0;
			for (int i = 0; i < N_OUT; i++) begin
				fsel_r[i] <= shm_pkg::FSEL_RST;
			end
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			enable_r <= enable_nxt;
			fault_rst_r <= fault_rst_nxt;
			irq_st_r <= irq_st_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= irq_nxt;
			for (int i = 0; i < N_OUT; i++) begin
				fsel_r[i] <= fsel_nxt[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Safe-halt monitor
	// ------------------------------------------------------------
	logic a_hi, a_lo, b_hi, b_lo, start_s, halt_s;

	assign a_hi = pins.clean[shm_pkg::PIN_A_HI];
	assign a_lo = pins.clean[shm_pkg::PIN_A_LO];
	assign b_hi = pins.clean[shm_pkg::PIN_B_HI];
	assign b_lo = pins.clean[shm_pkg::PIN_B_LO];
	assign start_s = pins.clean[shm_pkg::PIN_START];
	assign halt_s = pins.clean[shm_pkg::PIN_HALT];
	assign any_fault = mismatch_r | ext_fault_i;

	always_comb begin
		// Between thresholds a channel keeps its last level; low wins
		level_a_nxt = level_a_r;
		if (a_lo) begin
			level_a_nxt = 1'b0;
		end else if (a_hi) begin
			level_a_nxt = 1'b1;
		end
		level_b_nxt = level_b_r;
		if (b_lo) begin
			level_b_nxt = 1'b0;
		end else if (b_hi) begin
			level_b_nxt = 1'b1;
		end

		if (!enable_r) begin
			sto_nxt = 1'b0;
		end else if (sto_r) begin
			sto_nxt = ~(level_a_r & level_b_r);
		end else begin
			sto_nxt = ~level_a_r & ~level_b_r;
		end

		// Saturates so a long disagreement cannot wrap and hide
		cnt_nxt = '0;
		if (enable_r && level_a_r != level_b_r) begin
			cnt_nxt = (cnt_r == CNT_LIMIT) ? cnt_r : cnt_r + CNT_ONE;
		end

		mismatch_nxt = mismatch_r;
		if (fault_rst_r) begin
			mismatch_nxt = 1'b0;
		end
		if (cnt_r == CNT_LIMIT) begin
			mismatch_nxt = 1'b1;
		end

		// Three-wire: start pulse latches run, open halt drops it
		start_d_nxt = start_s;
		ext_d_nxt = ext_fault_i;
		run_nxt = run_r;
		if (!halt_s) begin
			run_nxt = 1'b0;
		end else if (start_s & ~start_d_r) begin
			run_nxt = 1'b1;
		end
		if (sto_r | any_fault | undervoltage_i) begin
			run_nxt = 1'b0;
		end

		if (sto_r) begin
			state_nxt = shm_pkg::ST_TORQUE_OFF_S;
		end else if (any_fault) begin
			state_nxt = shm_pkg::ST_FAULT;
		end else if (undervoltage_i) begin
			state_nxt = shm_pkg::ST_UNDERVOLT;
		end else if (dc_braking_i) begin
			state_nxt = shm_pkg::ST_DC_BRAKE;
		end else if (self_tuning_i) begin
			state_nxt = shm_pkg::ST_TUNING;
		end else if (configuration_i) begin
			state_nxt = shm_pkg::ST_CONFIG;
		end else if (run_r) begin
			state_nxt = shm_pkg::ST_RUN_S;
		end else begin
			state_nxt = shm_pkg::ST_READY;
		end

		irq_evt = '0;
		irq_evt[shm_pkg::IRQ_TORQUE_OFF] = sto_nxt & ~sto_r;
		irq_evt[shm_pkg::IRQ_MISMATCH] = mismatch_nxt & ~mismatch_r;
		irq_evt[shm_pkg::IRQ_EXT_FAULT] = ext_fault_i & ~ext_d_r;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_a_r <= 1'b0;
			level_b_r <= 1'b0;
			sto_r <= 1'b0;
			cnt_r <= '0;
			mismatch_r <= 1'b0;
			run_r <= 1'b0;
			start_d_r <= 1'b0;
			ext_d_r <= 1'b0;
			state_r <= shm_pkg::ST_READY;
		end else begin
			level_a_r <= level_a_nxt;
			level_b_r <= level_b_nxt;
			sto_r <= sto_nxt;
			cnt_r <= cnt_nxt;
			mismatch_r <= mismatch_nxt;
			run_r <= run_nxt;
			start_d_r <= start_d_nxt;
			ext_d_r <= ext_d_nxt;
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// Configurable outputs
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_out
			always_comb begin
				unique case (fsel_r[g])
					shm_pkg::FSEL_TORQUE_OFF: dout_nxt[g] = sto_r;
					shm_pkg::FSEL_MISMATCH: dout_nxt[g] = mismatch_r;
					shm_pkg::FSEL_ANY_FAULT: dout_nxt[g] = any_fault;
					shm_pkg::FSEL_NO_FAULT: dout_nxt[g] = ~any_fault;
					default: dout_nxt[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dout_r <= '0;
		end else begin
			dout_r <= dout_nxt;
		end
	end

	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign drive_state_param_o = state_r;
	assign torque_off_state_o = sto_r;
	assign channel_mismatch_fault_o = mismatch_r;
	assign run_o = run_r;
	assign digital_out_o = dout_r;
	assign irq_o = irq_r;
endmodule

// ### rtl/shm_pkg.sv
package shm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned MISMATCH_MS = 100;
	localparam int unsigned MISMATCH_CYCLES = MISMATCH_MS * CLK_KHZ;
	localparam int unsigned MISMATCH_CNT_W = 24;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int unsigned N_OUT = 5;
	localparam int unsigned FSEL_W = 8;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned N_PIN = 6;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_FSEL0 = 6'h10;
	localparam logic [ADDR_W-1:0] FSEL_STRIDE = 6'h04;

	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_FAULT_RST = 1;
	localparam logic CTRL_ENABLE_RST = 1'b1;

	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_LEVEL_A = 4;
	localparam int unsigned ST_LEVEL_B = 5;
	localparam int unsigned ST_TORQUE_OFF = 6;
	localparam int unsigned ST_MISMATCH = 7;
	localparam int unsigned ST_ANY_FAULT = 8;
	localparam int unsigned ST_RUN = 9;

	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_TORQUE_OFF = 0;
	localparam int unsigned IRQ_MISMATCH = 1;
	localparam int unsigned IRQ_EXT_FAULT = 2;

	// Pin vector positions
	localparam int unsigned PIN_A_HI = 0;
	localparam int unsigned PIN_A_LO = 1;
	localparam int unsigned PIN_B_HI = 2;
	localparam int unsigned PIN_B_LO = 3;
	localparam int unsigned PIN_START = 4;
	localparam int unsigned PIN_HALT = 5;

	// ------------------------------------------------------------
	// Output function codes
	// ------------------------------------------------------------
	localparam logic [FSEL_W-1:0] FSEL_TORQUE_OFF = 8'h21;
	localparam logic [FSEL_W-1:0] FSEL_MISMATCH = 8'h22;
	localparam logic [FSEL_W-1:0] FSEL_ANY_FAULT = 8'h0d;
	localparam logic [FSEL_W-1:0] FSEL_NO_FAULT = 8'h1a;
	localparam logic [FSEL_W-1:0] FSEL_RST = 8'h00;

	typedef enum logic [2:0] {
		ST_READY,
		ST_RUN_S,
		ST_UNDERVOLT,
		ST_FAULT,
		ST_TUNING,
		ST_CONFIG,
		ST_DC_BRAKE,
		ST_TORQUE_OFF_S
	} shm_state_t;

endpackage

// ### rtl/shm_pin_if.sv
interface shm_pin_if #(
	parameter int unsigned N = 6
);
	logic [N-1:0] raw;
	logic [N-1:0] clean;

	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ### rtl/shm_sync.sv
module shm_sync #(
	parameter int unsigned N = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Pins
	shm_pin_if.sync pins
);
	logic [N-1:0] s1_r, s2_r, s3_r, clean_r;
	logic [N-1:0] clean_nxt;

	// ------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			always_comb begin
				clean_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : clean_r[g];
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			clean_r <= '0;
		end else begin
			s1_r <= pins.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;
endmodule

// ### tb/shm_relay.sv
module shm_relay (
	// Clock
	input wire logic clk_i,
	// Safe-halt contacts, comparator pairs
	output logic a_hi_o,
	output logic a_lo_o,
	output logic b_hi_o,
	output logic b_lo_o,
	// Command pins
	output logic start_o,
	output logic halt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		a_hi_o = 1'b1;
		a_lo_o = 1'b0;
		b_hi_o = 1'b1;
		b_lo_o = 1'b0;
		start_o = 1'b0;
		halt_o = 1'b1;
	end
	// Skew above the mismatch limit only when a test asks for it
	task automatic set_ch(input logic a, input logic b, input int skew);
		@(posedge clk_i);
		a_hi_o <= a;
		a_lo_o <= !a;
		repeat (skew) @(posedge clk_i);
		b_hi_o <= b;
		b_lo_o <= !b;
	endtask
	task automatic start_pulse();
		@(posedge clk_i);
		halt_o <= 1'b1;
		start_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		start_o <= 1'b0;
	endtask
	task automatic ramp_stop(input int dly);
		@(posedge clk_i);
		halt_o <= 1'b0;
		repeat (dly) @(posedge clk_i);
		set_ch(1'b0, 1'b0, 0);
	endtask
	task automatic restart();
		set_ch(1'b1, 1'b1, 0);
		repeat (12) @(posedge clk_i);
		start_pulse();
	endtask
endmodule

// ### tb/shm_monitor_asserts.sv
module shm_monitor_chk #(
	parameter int unsigned MISMATCH_CYCLES = 50
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic safe_halt_in_a_hi_i,
	input wire logic safe_halt_in_a_lo_i,
	input wire logic safe_halt_in_b_hi_i,
	input wire logic safe_halt_in_b_lo_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic [2:0] drive_state_param_o,
	input wire logic torque_off_state_o,
	input wire logic channel_mismatch_fault_o,
	input wire logic run_o,
	input wire logic [4:0] digital_out_o
);
	logic wr_w, clr_w, en_r, en_nxt;
	logic [7:0] sel_r [5];
	logic [7:0] sel_nxt [5];
	logic [4:0] m_w, e_w;
	int unsigned dc_r, dc_nxt, dl_r, dl_nxt, ha_r, ha_nxt;
	assign wr_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign clr_w = wr_w && avs_address_i == shm_pkg::OFF_CTRL
		&& avs_writedata_i[1];
	// Raw pin disagreement; both channels share the same sync delay
	always_comb begin
		en_nxt = en_r;
		sel_nxt = sel_r;
		if (wr_w && avs_address_i == shm_pkg::OFF_CTRL)
			en_nxt = avs_writedata_i[0];
		for (int i = 0; i < 5; i++) begin
			if (wr_w && avs_address_i == shm_pkg::OFF_FSEL0
				+ 6'(i) * shm_pkg::FSEL_STRIDE)
				sel_nxt[i] = avs_writedata_i[7:0];
			m_w[i] = sel_r[i] inside {8'h21, 8'h22};
			e_w[i] = (sel_r[i] == 8'h21 && torque_off_state_o)
				|| (sel_r[i] == 8'h22 && channel_mismatch_fault_o);
		end
		dc_nxt = (safe_halt_in_a_hi_i ^ safe_halt_in_b_hi_i) ? dc_r + 1 : 0;
		dl_nxt = (dc_nxt == 0 && dc_r != 0) ? dc_r : dl_r;
		ha_nxt = (safe_halt_in_a_hi_i && safe_halt_in_b_hi_i) ? 0
			: (ha_r < 99 ? ha_r + 1 : ha_r);
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_r <= 1'b1;
			sel_r <= '{default: 8'h00};
			dc_r <= 0;
			dl_r <= 0;
			ha_r <= 0;
		end else begin
			en_r <= en_nxt;
			sel_r <= sel_nxt;
			dc_r <= dc_nxt;
			dl_r <= dl_nxt;
			ha_r <= ha_nxt;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_both_low;
		safe_halt_in_a_lo_i && safe_halt_in_b_lo_i;
	endsequence
	sequence s_sto_held;
		torque_off_state_o ##1 torque_off_state_o;
	endsequence
	property p_sto_enter;
		s_both_low [*8] ##0 en_r |-> ##[0:6] torque_off_state_o;
	endproperty
	property p_sto_state;
		s_sto_held |-> drive_state_param_o == shm_pkg::ST_TORQUE_OFF_S;
	endproperty
	property p_sto_run;
		s_sto_held |-> !run_o;
	endproperty
	property p_sto_leave;
		$fell(torque_off_state_o) && en_r |-> ha_r < 12;
	endproperty
	property p_mm_hold;
		channel_mismatch_fault_o && !clr_w && !$past(clr_w)
			|=> channel_mismatch_fault_o;
	endproperty
	property p_mm_rise;
		$rose(channel_mismatch_fault_o)
			|-> dc_r >= MISMATCH_CYCLES || dl_r >= MISMATCH_CYCLES;
	endproperty
	property p_mm_bound;
		en_r && dc_r == MISMATCH_CYCLES + 20 |-> channel_mismatch_fault_o;
	endproperty
	property p_out_map;
		(digital_out_o & $past(m_w)) == $past(e_w);
	endproperty
	a_sto_enter: assert property (p_sto_enter)
		else $error("torque-off not entered");
	a_sto_state: assert property (p_sto_state)
		else $error("state not torque-off");
	a_sto_run: assert property (p_sto_run)
		else $error("running during torque-off");
	a_sto_leave: assert property (p_sto_leave)
		else $error("torque-off left without both channels");
	a_mm_hold: assert property (p_mm_hold)
		else $error("mismatch fault dropped without reset");
	a_mm_rise: assert property (p_mm_rise)
		else $error("mismatch fault too early");
	a_mm_bound: assert property (p_mm_bound)
		else $error("mismatch fault missing");
	a_out_map: assert property (p_out_map)
		else $error("output select 33 or 34 wrong");
endmodule

bind shm_monitor shm_monitor_chk #(.MISMATCH_CYCLES(MISMATCH_CYCLES)) u_chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i),
	.safe_halt_in_a_hi_i(safe_halt_in_a_hi_i),
	.safe_halt_in_a_lo_i(safe_halt_in_a_lo_i),
	.safe_halt_in_b_hi_i(safe_halt_in_b_hi_i),
	.safe_halt_in_b_lo_i(safe_halt_in_b_lo_i),
	.avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.drive_state_param_o(drive_state_param_o),
	.torque_off_state_o(torque_off_state_o),
	.channel_mismatch_fault_o(channel_mismatch_fault_o),
	.run_o(run_o), .digital_out_o(digital_out_o)
);

// ### tb/safe_halt_monitor_tb_top.sv
module safe_halt_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int M = 50;
	logic clk_i = 0, reset_n_i = 0, a_hi, a_lo, b_hi, b_lo, start, halt;
	logic ext_i = 0, uv_i = 0, tu_i = 0, cf_i = 0, dcb_i = 0;
	logic rd = 0, wr = 0, wt, irq, torque_off_state, mm, run;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, rdata, q;
	logic [3:0] be = 0;
	logic [2:0] st;
	logic [4:0] dout;
	logic [15:0] lf = 16'h2c43;
	logic [7:0] m_sel [5] = '{default: 8'h00};
	int failures = 0, n_checks = 0;
	int m_sto, m_mm, m_ext, m_run, m_irq, m_mask, m_uv, m_dc, m_tu, m_cf;
	shm_monitor #(.MISMATCH_CYCLES(M)) DUT (
		.clk_i(clk_i), .reset_n_i(reset_n_i),
		.safe_halt_in_a_hi_i(a_hi), .safe_halt_in_a_lo_i(a_lo),
		.safe_halt_in_b_hi_i(b_hi), .safe_halt_in_b_lo_i(b_lo),
		.start_cmd_input_i(start), .halt_cmd_input_i(halt),
		.ext_fault_i(ext_i), .undervoltage_i(uv_i), .self_tuning_i(tu_i),
		.configuration_i(cf_i), .dc_braking_i(dcb_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wt),
		.drive_state_param_o(st), .torque_off_state_o(torque_off_state),
		.channel_mismatch_fault_o(mm), .run_o(run),
		.digital_out_o(dout), .irq_o(irq)
	);
	shm_relay u_relay (.clk_i(clk_i), .a_hi_o(a_hi), .a_lo_o(a_lo),
		.b_hi_o(b_hi), .b_lo_o(b_lo), .start_o(start), .halt_o(halt));
	initial forever #4 clk_i = ~clk_i;
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
	end
	// ------
	// Helpers
	// ------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [5:0] fa(input int i);
		return shm_pkg::OFF_FSEL0 + 6'(i) * shm_pkg::FSEL_STRIDE;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= b;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wt !== 1'b0 && n < 50);
		if (n >= 50)
			failures++;
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrt(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(q, e);
	endtask
	task automatic cmp_all();
		int f, s;
		logic [4:0] e;
		repeat (12) @(posedge clk_i);
		f = m_mm | m_ext;
		s = m_sto ? 7 : f ? 3 : m_uv ? 2 : m_dc ? 6 : m_tu ? 4 : m_cf ? 5
			: m_run;
		for (int i = 0; i < 5; i++)
			e[i] = m_sel[i] == 8'h21 ? m_sto != 0 : m_sel[i] == 8'h22
				? m_mm != 0 : m_sel[i] == 8'h0d ? f != 0
				: m_sel[i] == 8'h1a ? f == 0 : 1'b0;
		chk({irq, run, mm, torque_off_state, st, dout}, {(m_irq & m_mask) != 0,
			m_run[0], m_mm[0], m_sto[0], s[2:0], e});
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_i);
		failures++;
		summarize();
	end
	// ------
	// Tests
	// ------
	initial begin
		@(posedge reset_n_i);
		repeat (20) @(posedge clk_i);
		m_irq = 1;
		rdchk(shm_pkg::OFF_CTRL, 32'h1);
		rdchk(shm_pkg::OFF_STATUS, 32'h30);
		rdchk(shm_pkg::OFF_IRQ_ST, 32'h1);
		wrt(6'h3c, 32'hff);
		rdchk(6'h3c, 32'h0);
		for (int i = 0; i < 5; i++)
			rdchk(fa(i), 32'h0);
		wrt(shm_pkg::OFF_IRQ_ST, 32'h1);
		m_irq = 0;
		$display("reset values done");
		m_sel[0:3] = '{shm_pkg::FSEL_TORQUE_OFF, shm_pkg::FSEL_MISMATCH,
			shm_pkg::FSEL_ANY_FAULT, shm_pkg::FSEL_NO_FAULT};
		lf = lfsr(lf);
		m_sel[4] = lf[7:0];
		for (int i = 0; i < 5; i++)
			wrt(fa(i), {24'h0, m_sel[i]});
		bus(1'b1, fa(0), 32'h0, 4'he);
		rdchk(fa(0), 32'h21);
		cmp_all();
		$display("output selects done");
		wrt(shm_pkg::OFF_IRQ_MASK, 32'h7);
		m_mask = 7;
		u_relay.restart();
		m_run = 1;
		cmp_all();
		u_relay.ramp_stop(30);
		m_run = 0;
		m_sto = 1;
		m_irq = 1;
		cmp_all();
		u_relay.start_pulse();
		cmp_all();
		wrt(shm_pkg::OFF_IRQ_ST, 32'h1);
		m_irq = 0;
		cmp_all();
		u_relay.restart();
		m_sto = 0;
		m_run = 1;
		cmp_all();
		$display("torque-off done");
		u_relay.set_ch(1'b1, 1'b0, 0);
		repeat (M + 40) @(posedge clk_i);
		m_mm = 1;
		m_run = 0;
		m_irq = 2;
		cmp_all();
		u_relay.set_ch(1'b1, 1'b1, 0);
		cmp_all();
		wrt(shm_pkg::OFF_CTRL, 32'h3);
		m_mm = 0;
		cmp_all();
		u_relay.set_ch(1'b0, 1'b0, M - 10);
		m_sto = 1;
		m_irq = 3;
		cmp_all();
		u_relay.set_ch(1'b1, 1'b1, M + 30);
		m_sto = 0;
		m_mm = 1;
		cmp_all();
		wrt(shm_pkg::OFF_CTRL, 32'h3);
		m_mm = 0;
		$display("mismatch done");
		for (int k = 0; k < 8; k++) begin
			lf = lfsr(lf);
			m_mask = lf[3:1];
			wrt(shm_pkg::OFF_IRQ_MASK, {29'h0, lf[3:1]});
			if (lf[0] && m_ext == 0)
				m_irq |= 4;
			m_ext = lf[0];
			if (lf[0])
				m_run = 0;
			@(posedge clk_i);
			ext_i <= lf[0];
			cmp_all();
		end
		@(posedge clk_i);
		ext_i <= 1'b0;
		m_ext = 0;
		for (int k = 0; k < 5; k++) begin
			m_uv = k == 0;
			m_dc = k == 1;
			m_tu = k == 2;
			m_cf = k == 3;
			@(posedge clk_i);
			{uv_i, dcb_i, tu_i, cf_i} <= 4'(4'h8 >> k);
			cmp_all();
		end
		$display("faults and states done");
		wrt(shm_pkg::OFF_CTRL, 32'h0);
		u_relay.set_ch(1'b0, 1'b0, 0);
		cmp_all();
		u_relay.set_ch(1'b1, 1'b0, 0);
		repeat (M + 40) @(posedge clk_i);
		cmp_all();
		u_relay.set_ch(1'b1, 1'b1, 0);
		wrt(shm_pkg::OFF_CTRL, 32'h1);
		cmp_all();
		$display("disable done");
		summarize();
	end
endmodule
